//--- rtl/host_bus_pin_interface.sv
// Purpose: pin-level host bus port: straps, decode, address latch, access capture
// Assumes: host pins synchronous to mclk_i; one clock domain
// Notes:   accesses leave as one-cycle pulses with address, and data on writes
//
// Operation
// - in synchronous mode a high direction select means write and a low one means read.
// - an access is decoded only while the active-low address qualifier is low; with latching on, the code uses the latched qualifier instead.
// - in asynchronous mode a low write strobe marks the write cycle.
// - when latching is used, address bits 15 to 1 and the qualifier are caught on the address strobe rising edge.
// - with no serial ROM the ROM data input is a width strap, low 8-bit, high 16-bit, ignored for 32-bit.
// - in asynchronous mode a low read strobe marks the read cycle.
// - the local select output is low, combinationally, while the qualifier is low and bits 15 to 4 hit the base.
// - a low or floating bus mode strap selects synchronous mode, a high one asynchronous mode.
`timescale 1ns/1ps
module host_bus_pin_interface (
    input  wire logic                                        mclk_i,
    input  wire logic                                        reset_n_i,
    input  wire logic                                        clk_en_i,
    input  wire logic [host_bus_pkg::ADDR_HI:host_bus_pkg::ADDR_LO] addr_i,
    input  wire logic [host_bus_pkg::DATA_W-1:0]             write_data_i,
    input  wire logic [host_bus_pkg::ADDR_HI:host_bus_pkg::DECODE_LO] base_addr_i,
    input  wire logic                                        address_qualifier_n_i,
    input  wire logic                                        address_latch_strobe_n_i,
    input  wire logic                                        addr_latch_en_i,
    input  wire logic                                        sync_direction_select_i,
    input  wire logic                                        cycle_indicator_n_i,
    input  wire logic                                        write_strobe_n_i,
    input  wire logic                                        read_strobe_n_i,
    input  wire logic                                        serial_rom_data_input_i,
    input  wire logic                                        serial_rom_present_strap_i,
    input  wire logic                                        bus_mode_strap_i,
    input  wire logic                                        bus32_variant_i,
    output logic                                             local_select_n_o,
    output logic                                             wr_pulse_o,
    output logic                                             rd_pulse_o,
    output host_bus_pkg::access_t                            access_o,
    output host_bus_pkg::strap_cfg_t                         strap_cfg_o,
    output logic                                             strap_valid_o
);

    function automatic logic addr_hit(
        input logic [host_bus_pkg::ADDR_HI:host_bus_pkg::ADDR_LO]     a,
        input logic [host_bus_pkg::ADDR_HI:host_bus_pkg::DECODE_LO]   b
    );
        addr_hit = (a[host_bus_pkg::ADDR_HI:host_bus_pkg::DECODE_LO] == b);
    endfunction

    logic [host_bus_pkg::ADDR_HI:host_bus_pkg::ADDR_LO] lat_addr_q;
    logic                                               lat_aq_n_q;
    logic                                               ads_n_prev_q;
    logic                                               wr_n_prev_q;
    logic                                               rd_n_prev_q;
    logic                                               cyc_n_prev_q;
    logic [host_bus_pkg::ADDR_HI:host_bus_pkg::ADDR_LO] eff_addr;
    logic                                               eff_aq_n;
    logic                                               sel;
    logic                                               async_wr;
    logic                                               async_rd;
    logic                                               sync_go;
    logic                                               do_wr;
    logic                                               do_rd;

    // live decode, not registered
    assign local_select_n_o = !(!address_qualifier_n_i && addr_hit(addr_i, base_addr_i));

    // address and qualifier as seen by the access logic
    assign eff_addr = addr_latch_en_i ? lat_addr_q : addr_i;
    assign eff_aq_n = addr_latch_en_i ? lat_aq_n_q : address_qualifier_n_i;
    assign sel      = strap_valid_o && !eff_aq_n && addr_hit(eff_addr, base_addr_i);

    assign async_wr = (strap_cfg_o.mode == host_bus_pkg::MODE_ASYNC) && !wr_n_prev_q && write_strobe_n_i;
    assign async_rd = (strap_cfg_o.mode == host_bus_pkg::MODE_ASYNC) && rd_n_prev_q && !read_strobe_n_i;
    assign sync_go  = (strap_cfg_o.mode == host_bus_pkg::MODE_SYNC) && cyc_n_prev_q && !cycle_indicator_n_i;
    assign do_wr    = sel && (async_wr || (sync_go && sync_direction_select_i));
    assign do_rd    = sel && (async_rd || (sync_go && !sync_direction_select_i));

    // strap capture once after reset release
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            strap_cfg_o   <= host_bus_pkg::STRAP_RESET;
            strap_valid_o <= 1'b0;
        end else if (clk_en_i && !strap_valid_o) begin
            strap_valid_o    <= 1'b1;
            strap_cfg_o.mode <= bus_mode_strap_i ? host_bus_pkg::MODE_ASYNC : host_bus_pkg::MODE_SYNC;
            if (bus32_variant_i) begin
                strap_cfg_o.width <= host_bus_pkg::WIDTH_32;
            end else if (!serial_rom_present_strap_i) begin
                strap_cfg_o.width <= serial_rom_data_input_i ? host_bus_pkg::WIDTH_16 : host_bus_pkg::WIDTH_8;
            end else begin
                strap_cfg_o.width <= host_bus_pkg::WIDTH_16;
            end
        end
    end

    // address latch on strobe rising edge
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            lat_addr_q   <= '0;
            lat_aq_n_q   <= 1'b1;
            ads_n_prev_q <= 1'b1;
        end else if (clk_en_i) begin
            ads_n_prev_q <= address_latch_strobe_n_i;
            if (!ads_n_prev_q && address_latch_strobe_n_i) begin
                lat_addr_q <= addr_i;
                lat_aq_n_q <= address_qualifier_n_i;
            end
        end
    end

    // strobe history for edge detection
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_n_prev_q  <= 1'b1;
            rd_n_prev_q  <= 1'b1;
            cyc_n_prev_q <= 1'b1;
        end else if (clk_en_i) begin
            wr_n_prev_q  <= write_strobe_n_i;
            rd_n_prev_q  <= read_strobe_n_i;
            cyc_n_prev_q <= cycle_indicator_n_i;
        end
    end

    // access capture; sync direction comes from the host's direction select
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            wr_pulse_o <= 1'b0;
            rd_pulse_o <= 1'b0;
            access_o   <= host_bus_pkg::ACCESS_RESET;
        end else if (clk_en_i) begin
            wr_pulse_o <= do_wr;
            rd_pulse_o <= do_rd && !do_wr;
            if (do_wr) begin
                access_o.addr  <= eff_addr;
                access_o.write <= 1'b1;
                access_o.data  <= write_data_i;
            end else if (do_rd) begin
                access_o.addr  <= eff_addr;
                access_o.write <= 1'b0;
            end
        end
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);

    property p_async_write;
        clk_en_i && sel && strap_cfg_o.mode == host_bus_pkg::MODE_ASYNC && !wr_n_prev_q && write_strobe_n_i
            |=> wr_pulse_o && access_o.write && access_o.data == $past(write_data_i);
    endproperty
    a_async_write: assert property (p_async_write) else $error("write strobe rise not taken");

    property p_async_read;
        clk_en_i && sel && !async_wr && strap_cfg_o.mode == host_bus_pkg::MODE_ASYNC && rd_n_prev_q && !read_strobe_n_i
            |=> rd_pulse_o && !access_o.write;
    endproperty
    a_async_read: assert property (p_async_read) else $error("read strobe fall not taken");

    property p_sync_dir;
        clk_en_i && sel && strap_cfg_o.mode == host_bus_pkg::MODE_SYNC && cyc_n_prev_q && !cycle_indicator_n_i
            |=> (wr_pulse_o == $past(sync_direction_select_i)) && (rd_pulse_o == !$past(sync_direction_select_i));
    endproperty
    a_sync_dir: assert property (p_sync_dir) else $error("sync direction wrong");

    property p_qual_blocks;
        clk_en_i && eff_aq_n |=> !wr_pulse_o && !rd_pulse_o && $stable(access_o);
    endproperty
    a_qual_blocks: assert property (p_qual_blocks) else $error("access taken with qualifier high");

    property p_decode_gate;
        (wr_pulse_o || rd_pulse_o) |-> access_o.addr[host_bus_pkg::ADDR_HI:host_bus_pkg::DECODE_LO] == $past(base_addr_i);
    endproperty
    a_decode_gate: assert property (p_decode_gate) else $error("access outside base");

    property p_latch;
        clk_en_i && !ads_n_prev_q && address_latch_strobe_n_i
            |=> lat_addr_q == $past(addr_i) && lat_aq_n_q == $past(address_qualifier_n_i);
    endproperty
    a_latch: assert property (p_latch) else $error("address not latched");

    property p_local_select;
        !address_qualifier_n_i && addr_hit(addr_i, base_addr_i) |-> !local_select_n_o;
    endproperty
    a_local_select: assert property (p_local_select) else $error("local select not low on hit");

    property p_width_strap;
        $rose(strap_valid_o) && !$past(bus32_variant_i) && !$past(serial_rom_present_strap_i)
            |-> strap_cfg_o.width == ($past(serial_rom_data_input_i) ? host_bus_pkg::WIDTH_16 : host_bus_pkg::WIDTH_8);
    endproperty
    a_width_strap: assert property (p_width_strap) else $error("width strap wrong");

    property p_mode_strap;
        $rose(strap_valid_o) |-> (strap_cfg_o.mode == host_bus_pkg::MODE_ASYNC) == $past(bus_mode_strap_i);
    endproperty
    a_mode_strap: assert property (p_mode_strap) else $error("mode strap wrong");

    property p_async_only_strobes;
        clk_en_i && strap_valid_o && strap_cfg_o.mode == host_bus_pkg::MODE_ASYNC
            && (wr_n_prev_q || !write_strobe_n_i) && (!rd_n_prev_q || read_strobe_n_i)
            |=> !wr_pulse_o && !rd_pulse_o;
    endproperty
    a_async_only_strobes: assert property (p_async_only_strobes) else $error("async access without strobe");

    property p_sync_only_cycle;
        clk_en_i && strap_cfg_o.mode == host_bus_pkg::MODE_SYNC && !(cyc_n_prev_q && !cycle_indicator_n_i)
            |=> !wr_pulse_o && !rd_pulse_o;
    endproperty
    a_sync_only_cycle: assert property (p_sync_only_cycle) else $error("sync access without cycle start");

    property p_latched_addr;
        clk_en_i && addr_latch_en_i && (do_wr || do_rd) |=> access_o.addr == $past(lat_addr_q);
    endproperty
    a_latched_addr: assert property (p_latched_addr) else $error("latched address not used");

    property p_read_keeps_data;
        clk_en_i && do_rd && !do_wr |=> $stable(access_o.data) && !access_o.write;
    endproperty
    a_read_keeps_data: assert property (p_read_keeps_data) else $error("read changed write data");

    property p_freeze;
        !clk_en_i |=> $stable(access_o) && $stable(wr_pulse_o) && $stable(rd_pulse_o)
            && $stable(strap_cfg_o) && $stable(strap_valid_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

endmodule // host_bus_pin_interface

//--- rtl/host_bus_pkg.sv
// Purpose: shared types and constants of the host bus pin interface
// Assumes: all host pins already synchronous to mclk_i
// Notes:   bus width and mode come from straps caught after reset
package host_bus_pkg;

    localparam int ADDR_HI     = 15;
    localparam int ADDR_LO     = 1;
    localparam int DECODE_LO   = 4;
    localparam int DATA_W      = 32;

    typedef enum logic [1:0] {
        WIDTH_8  = 2'b00,
        WIDTH_16 = 2'b01,
        WIDTH_32 = 2'b10
    } bus_width_t;

    typedef enum logic [0:0] {
        MODE_SYNC  = 1'b0,
        MODE_ASYNC = 1'b1
    } bus_mode_t;

    // straps as caught after reset
    typedef struct packed {
        bus_mode_t  mode;
        bus_width_t width;
    } strap_cfg_t;

    localparam strap_cfg_t STRAP_RESET = '{mode: MODE_SYNC, width: WIDTH_8};

    // one accepted host access
    typedef struct packed {
        logic [ADDR_HI:ADDR_LO] addr;
        logic                   write;
        logic [DATA_W-1:0]      data;
    } access_t;

    localparam access_t ACCESS_RESET = '0;

endpackage

//--- test/host_model.sv
// Purpose: host cpu model driving the host bus pins
// Assumes: pins change just after the mclk rising edge
// Notes:   released address/data show the inverted last value
`timescale 1ns/1ps
module host_model (
    input  wire logic        clk_i,
    output logic [15:1]      addr_o,
    output logic [31:0]      data_o,
    output logic             aq_n_o,
    output logic             ads_n_o,
    output logic             dir_o,
    output logic             cyc_n_o,
    output logic             wr_n_o,
    output logic             rd_n_o
);
    initial begin
        addr_o  = '0;
        data_o  = '0;
        dir_o   = 1'b0;
        aq_n_o  = 1'b1;
        ads_n_o = 1'b1;
        cyc_n_o = 1'b1;
        wr_n_o  = 1'b1;
        rd_n_o  = 1'b1;
    end
    // bus let go: pull-up on qualifier, address, data and direction inverted
    task automatic let_go();
        addr_o <= ~addr_o;
        data_o <= ~data_o;
        dir_o  <= ~dir_o;
        aq_n_o <= 1'b1;
    endtask
    task automatic async_op(input logic w, input logic [15:1] a, input logic [31:0] d, input logic q_n);
        @(posedge clk_i);
        addr_o <= a;
        data_o <= d;
        aq_n_o <= q_n;
        cyc_n_o <= !w;
        if (w) wr_n_o <= 1'b0;
        else rd_n_o <= 1'b0;
        @(posedge clk_i);
        wr_n_o <= 1'b1;
        rd_n_o <= 1'b1;
        @(posedge clk_i);
        let_go();
        cyc_n_o <= 1'b1;
    endtask
    task automatic sync_op(input logic w, input logic [15:1] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_o  <= a;
        data_o  <= d;
        aq_n_o  <= 1'b0;
        dir_o   <= w;
        cyc_n_o <= 1'b0;
        @(posedge clk_i);
        cyc_n_o <= 1'b1;
        @(posedge clk_i);
        let_go();
    endtask
    task automatic latch(input logic [15:1] a, input logic q_n);
        @(posedge clk_i);
        addr_o  <= a;
        aq_n_o  <= q_n;
        ads_n_o <= 1'b0;
        @(posedge clk_i);
        ads_n_o <= 1'b1;
        repeat (2) @(posedge clk_i);
        let_go();
    endtask
    task automatic put(input logic [15:1] a, input logic q_n);
        @(posedge clk_i);
        addr_o <= a;
        aq_n_o <= q_n;
    endtask
endmodule // host_model

//--- test/host_bus_pin_interface_tb.sv
// Purpose: self-checking bench of the host bus pin interface
// Assumes: host_model drives bus pins, bench drives straps
// Notes:   pulses are counted over a short window per access
`timescale 1ns/1ps
module host_bus_pin_interface_tb;
    localparam logic [15:4] BASE = 12'ha5c;
    localparam logic [15:1] HIT  = {BASE, 3'h3};
    localparam logic [15:1] MISS = {BASE ^ 12'h001, 3'h3};
    logic mclk_i = 1'b0, reset_n_i = 1'b0, lat_en = 1'b0, clk_en = 1'b1;
    logic mode_s = 1'b0, rom_p = 1'b0, rom_d = 1'b0, b32 = 1'b0;
    logic [15:1] addr;
    logic [31:0] data;
    logic aq_n, ads_n, dir, cyc_n, wr_n, rd_n, sel_n, wr_p, rd_p, s_valid;
    host_bus_pkg::access_t    acc;
    host_bus_pkg::strap_cfg_t cfg;
    int n_fail = 0, checks = 0;
    always #2.5 mclk_i = ~mclk_i;
    host_model i_host (.clk_i(mclk_i), .addr_o(addr), .data_o(data), .aq_n_o(aq_n), .ads_n_o(ads_n),
        .dir_o(dir), .cyc_n_o(cyc_n), .wr_n_o(wr_n), .rd_n_o(rd_n));
    host_bus_pin_interface i_dut (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en), .addr_i(addr),
        .write_data_i(data), .base_addr_i(BASE), .address_qualifier_n_i(aq_n), .address_latch_strobe_n_i(ads_n),
        .addr_latch_en_i(lat_en), .sync_direction_select_i(dir), .cycle_indicator_n_i(cyc_n),
        .write_strobe_n_i(wr_n), .read_strobe_n_i(rd_n), .serial_rom_data_input_i(rom_d),
        .serial_rom_present_strap_i(rom_p), .bus_mode_strap_i(mode_s), .bus32_variant_i(b32),
        .local_select_n_o(sel_n), .wr_pulse_o(wr_p), .rd_pulse_o(rd_p), .access_o(acc),
        .strap_cfg_o(cfg), .strap_valid_o(s_valid));
    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic do_reset(input logic [3:0] s);
        @(posedge mclk_i);
        reset_n_i <= 1'b0;
        {b32, rom_d, rom_p, mode_s} <= s;
        repeat (6) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
    endtask
    task automatic pulses(input logic ew, input logic er);
        int nw, nr;
        nw = 0;
        nr = 0;
        repeat (6) begin
            @(negedge mclk_i);
            nw += (wr_p === 1'b1);
            nr += (rd_p === 1'b1);
        end
        check("wr_pulse_count", nw, ew);
        check("rd_pulse_count", nr, er);
    endtask
    task automatic t_straps();
        host_bus_pkg::bus_width_t w;
        for (int i = 0; i < 16; i++) begin
            do_reset(i[3:0]);
            w = i[3] ? host_bus_pkg::WIDTH_32 : (i[1] | i[2]) ? host_bus_pkg::WIDTH_16 : host_bus_pkg::WIDTH_8;
            check("strap_width", cfg.width, w);
            check("strap_mode", cfg.mode, i[0]);
            check("strap_valid", s_valid, 1'b1);
        end
    endtask
    task automatic t_async();
        do_reset(4'h1);
        fork i_host.async_op(1'b1, HIT, 32'h1234_abcd, 1'b0); pulses(1'b1, 1'b0); join
        check("async_wr_access", acc, {HIT, 1'b1, 32'h1234_abcd});
        fork i_host.async_op(1'b0, HIT ^ 15'h0007, 32'h0000_5555, 1'b0); pulses(1'b0, 1'b1); join
        check("async_rd_access", acc, {HIT ^ 15'h0007, 1'b0, 32'h1234_abcd});
        fork i_host.async_op(1'b1, HIT, 32'h0f0f_0f0f, 1'b1); pulses(1'b0, 1'b0); join
        fork i_host.async_op(1'b1, MISS, 32'h0f0f_0f0f, 1'b0); pulses(1'b0, 1'b0); join
        check("refused_access", acc, {HIT ^ 15'h0007, 1'b0, 32'h1234_abcd});
    endtask
    task automatic t_sync();
        do_reset(4'h0);
        fork i_host.sync_op(1'b1, HIT, 32'h8765_4321); pulses(1'b1, 1'b0); join
        check("sync_wr_access", acc, {HIT, 1'b1, 32'h8765_4321});
        fork i_host.sync_op(1'b0, HIT, 32'h0000_0000); pulses(1'b0, 1'b1); join
        check("sync_rd_access", acc, {HIT, 1'b0, 32'h8765_4321});
    endtask
    task automatic t_select();
        logic [15:1] a[4] = '{HIT, {BASE, 3'h0}, MISS, {BASE ^ 12'h800, 3'h3}};
        logic q[4] = '{1'b0, 1'b0, 1'b0, 1'b0};
        for (int i = 0; i < 5; i++) begin
            i_host.put((i < 4) ? a[i] : HIT, (i < 4) ? q[i] : 1'b1);
            #1;
            check("local_select_n", sel_n, !(i < 2));
        end
    endtask
    task automatic t_latch();
        do_reset(4'h9);
        lat_en <= 1'b1;
        i_host.latch(HIT, 1'b0);
        fork i_host.async_op(1'b1, MISS, 32'h0000_0001, 1'b0); pulses(1'b1, 1'b0); join
        check("latched_access", acc, {HIT, 1'b1, 32'h0000_0001});
        i_host.latch(MISS, 1'b0);
        fork i_host.async_op(1'b1, HIT, 32'h0000_0002, 1'b0); pulses(1'b0, 1'b0); join
        @(posedge mclk_i);
        lat_en <= 1'b0;
    endtask
    task automatic t_freeze();
        do_reset(4'h1);
        clk_en <= 1'b0;
        fork i_host.async_op(1'b1, HIT, 32'h0000_00a5, 1'b0); pulses(1'b0, 1'b0); join
        check("frozen_access", acc, host_bus_pkg::ACCESS_RESET);
        @(posedge mclk_i);
        clk_en <= 1'b1;
        fork i_host.async_op(1'b1, HIT, 32'h0000_00a5, 1'b0); pulses(1'b1, 1'b0); join
        check("resumed_access", acc, {HIT, 1'b1, 32'h0000_00a5});
    endtask
    task automatic complete_run();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        t_straps();
        t_async();
        t_sync();
        t_select();
        t_latch();
        t_freeze();
        complete_run();
    end
    initial begin
        repeat (5000) @(posedge mclk_i);
        n_fail++;
        complete_run();
    end
endmodule // host_bus_pin_interface_tb
